// File: include/ocs_regs.svh
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

// Master oscillator period in clk_in cycles; must be even
`define OCS_MASTER_CLKS    2
// Start-up interval in master periods
`define OCS_START_PERIODS  500
// Code change latency = MULT * (|delta| + OFFSET) master periods
`define OCS_LAT_MULT       16
`define OCS_LAT_OFFSET     6
// Ratios at or above 2**SHORT_EXP get a one master period lead-in low
`define OCS_SHORT_EXP      3'h2
// Code bit that carries the float-when-disabled choice
`define OCS_FLOAT_POS      3

`endif

// File: include/ocs_pkg.sv
`default_nettype none
`include "ocs_regs.svh"

package ocs_pkg;

  typedef logic [3:0] ocs_code_type;
  typedef logic [2:0] ocs_exp_type;

  typedef enum logic {
    OCS_ST_START,
    OCS_ST_RUN
  } ocs_state_type;

  // Codes 0..7 give 2**code, 8..15 give 2**(15-code)
  function automatic ocs_exp_type ocs_exp_of(input ocs_code_type code);
    return code[`OCS_FLOAT_POS] ? ~code[2:0] : code[2:0];
  endfunction : ocs_exp_of

  function automatic logic ocs_float_of(input ocs_code_type code);
    return code[`OCS_FLOAT_POS];
  endfunction : ocs_float_of

endpackage : ocs_pkg

`default_nettype wire

// File: include/ocs_code_if.sv
`default_nettype none

interface ocs_code_if;
  import ocs_pkg::*;
  ocs_code_type code;
  logic         float_bit;
  ocs_exp_type  exp;
  logic         valid;
  logic         settled;
  modport src (output code, float_bit, exp, valid, settled);
  modport dst (input code, float_bit, exp, valid, settled);
endinterface : ocs_code_if

`default_nettype wire

// File: design/ocs_code_filter.sv
`default_nettype none
`include "ocs_regs.svh"

module ocs_code_filter #(
  parameter int MASTER_CLKS = `OCS_MASTER_CLKS
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire ocs_pkg::ocs_code_type raw_code_in,
  ocs_code_if.src                    code_if
);
  import ocs_pkg::*;
  localparam int CNT_W = 12;

  ocs_code_type     cand_q, cand_d, active_q, active_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, need_w;
  logic             valid_q, valid_d;

  // First code after reset is taken with a zero step
  function automatic logic [CNT_W-1:0] latency_cycles(input ocs_code_type a, input ocs_code_type b,
                                                       input logic use_delta);
    logic [CNT_W-1:0] delta;
    delta = (a > b) ? CNT_W'(a - b) : CNT_W'(b - a);
    if (!use_delta) delta = '0;
    return CNT_W'(`OCS_LAT_MULT * (delta + CNT_W'(`OCS_LAT_OFFSET)) * MASTER_CLKS);
  endfunction : latency_cycles

  always_comb begin
    need_w   = latency_cycles(cand_q, active_q, valid_q);
    cand_d   = cand_q;
    cnt_d    = cnt_q;
    active_d = active_q;
    valid_d  = valid_q;
    if (raw_code_in != cand_q) begin
      cand_d = raw_code_in;
      cnt_d  = '0;
    end else if (cnt_q < need_w) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q == need_w - 1'b1) begin
        active_d = cand_q;
        valid_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cand_q   <= '0;
      active_q <= '0;
      cnt_q    <= '0;
      valid_q  <= 1'b0;
    end else begin
      cand_q   <= cand_d;
      active_q <= active_d;
      cnt_q    <= cnt_d;
      valid_q  <= valid_d;
    end
  end

  assign code_if.code      = active_q;
  assign code_if.float_bit = ocs_float_of(active_q);
  assign code_if.exp       = ocs_exp_of(active_q);
  assign code_if.valid     = valid_q;
  assign code_if.settled   = valid_q && (cand_q == active_q) && (raw_code_in == cand_q);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_TRACK_CODE: assert property ((raw_code_in != cand_q) |=> cand_q == $past(raw_code_in))
    else $error("filter stopped tracking the pin code");
  AST_COMMIT_LATENCY: assert property ($changed(active_q) |-> $past(cnt_q) == $past(need_w) - 1'b1)
    else $error("code committed at the wrong count");
  AST_COMMIT_STABLE: assert property ($changed(active_q) |-> active_q == $past(raw_code_in) && active_q == $past(cand_q))
    else $error("unstable or intermediate code committed");

endmodule : ocs_code_filter

`default_nettype wire

// File: design/ocs_divider.sv
`default_nettype none
`include "ocs_regs.svh"

module ocs_divider #(
  parameter int MASTER_CLKS = `OCS_MASTER_CLKS
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 run_in,
  input  wire ocs_pkg::ocs_exp_type exp_in,
  output logic                      level_out
);
  import ocs_pkg::*;
  localparam int CNT_W = 16;

  logic [CNT_W-1:0] cnt_q, cnt_d, hi_q, hi_d;
  logic             level_q, level_d;
  ocs_exp_type      exp_q, exp_d;

  function automatic logic [CNT_W-1:0] half_cycles(input ocs_exp_type e);
    return CNT_W'((MASTER_CLKS << e) >> 1);
  endfunction : half_cycles

  always_comb begin
    level_d = level_q;
    exp_d   = exp_q;
    cnt_d   = cnt_q - 1'b1;
    hi_d    = level_q ? hi_q + 1'b1 : '0;
    if (!run_in) begin
      level_d = 1'b0;
      exp_d   = exp_in;
      // Short lead-in low for the larger ratios, half period otherwise
      cnt_d   = ((exp_in >= `OCS_SHORT_EXP) ? CNT_W'(MASTER_CLKS) : half_cycles(exp_in)) - 1'b1;
    end else if (cnt_q == '0) begin
      level_d = ~level_q;
      if (level_q) begin
        // Ratio swaps only at the end of a full period
        exp_d = exp_in;
        cnt_d = half_cycles(exp_in) - 1'b1;
      end else begin
        cnt_d = half_cycles(exp_q) - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cnt_q   <= '0;
      hi_q    <= '0;
      level_q <= 1'b0;
      exp_q   <= '0;
    end else begin
      cnt_q   <= cnt_d;
      hi_q    <= hi_d;
      level_q <= level_d;
      exp_q   <= exp_d;
    end
  end

  assign level_out = level_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_GLITCHLESS_SWAP: assert property ($past(run_in) && $changed(exp_q) |-> $fell(level_q))
    else $error("ratio changed in mid period");
  AST_HIGH_WIDTH: assert property ($fell(level_q) && $past(run_in) |-> hi_q == half_cycles($past(exp_q)))
    else $error("high phase width does not match ratio");

endmodule : ocs_divider

`default_nettype wire

// File: design/ocs_top.sv
`default_nettype none
`include "ocs_regs.svh"

// Function
// - Keep sampling the pin code after start-up to catch later changes.
// - New code takes effect after 16*(|delta|+6) master periods.
// - Accept a code only once stable; jump straight to it, no intermediate codes.
// - Settling filter confirms the code before ratio or float bit change.
// - Ratio changes switch cleanly at a period end, no sliver pulses.
// - Reset starts start-up; the pin floats for the whole interval.
// - Start-up lasts at least 500 master periods whatever the ratio.
// - Start-up stretches until the pin code is stable.
// - Enabled at start-up end: low one master period, half period below ratio 4.
// - Disabled at start-up end: drive low, or float when float bit set.
// - One code sets both the ratio and the float bit.
// - Codes 0-7 give 2**code; 8-15 give 2**(15-code) with float set.
// - Enable high passes the clock; low floats or holds low per float bit.
// - Rising enable synchronised so the first pulse has full width.
// - Falling enable cuts the output at once, truncating a high pulse.
module ocs_top #(
  parameter int MASTER_CLKS   = `OCS_MASTER_CLKS,
  parameter int START_PERIODS = `OCS_START_PERIODS
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire ocs_pkg::ocs_code_type divider_select_code_in,
  input  wire logic                  output_enable_in,
  output logic                       clk_pin_out,
  output logic                       clk_pin_oe_out,
  output logic                       startup_done_out,
  output ocs_pkg::ocs_code_type      active_code_out,
  output logic                       float_when_disabled_out
);
  import ocs_pkg::*;

  localparam int                START_W    = 16;
  localparam int                START_CYC  = START_PERIODS * MASTER_CLKS;
  localparam logic [START_W-1:0] START_LAST = START_W'(START_CYC);

  ocs_state_type      state_q, state_d;
  logic [START_W-1:0] start_cnt_q, start_cnt_d;
  logic               en_q, en_d;
  logic               pin_q, pin_d;
  logic               pin_oe_q, pin_oe_d;
  logic               done_q, done_d;
  ocs_code_type       code_q, code_d;
  logic               float_q, float_d;
  logic               running;
  logic               div_run;
  logic               div_level;

  ocs_code_if code_if ();

  // Settling filter runs from reset on, through start-up and after it
  ocs_code_filter #(
    .MASTER_CLKS (MASTER_CLKS)
  ) u_filter (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .raw_code_in (divider_select_code_in),
    .code_if     (code_if)
  );

  ocs_divider #(
    .MASTER_CLKS (MASTER_CLKS)
  ) u_divider (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .run_in     (div_run),
    .exp_in     (code_if.exp),
    .level_out  (div_level)
  );

  // Start-up sequencer
  always_comb begin
    state_d     = state_q;
    start_cnt_d = start_cnt_q;
    unique case (state_q)
      OCS_ST_START: begin
        if (start_cnt_q != START_LAST) begin
          start_cnt_d = start_cnt_q + 1'b1;
        end else if (code_if.valid && code_if.settled) begin
          state_d = OCS_ST_RUN;
        end
      end
      OCS_ST_RUN: begin
        state_d = OCS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q     <= OCS_ST_START;
      start_cnt_q <= '0;
    end else begin
      state_q     <= state_d;
      start_cnt_q <= start_cnt_d;
    end
  end

  assign running = (state_q == OCS_ST_RUN);

  // Output pin control
  // The divider starts only a cycle after enable rises, so it always begins
  // in its low lead-in phase; the price is one extra clk of enable latency.
  always_comb begin
    en_d     = output_enable_in;
    // Using the raw enable here drops the pin on the very next edge
    div_run  = running && en_q && output_enable_in;
    pin_d    = div_run && div_level;
    // Floats through start-up, then per enable and float bit
    pin_oe_d = running && (output_enable_in || !code_if.float_bit);
    done_d   = running;
    code_d   = code_if.valid ? code_if.code : code_q;
    float_d  = code_if.valid ? code_if.float_bit : float_q;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      en_q     <= 1'b0;
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
      done_q   <= 1'b0;
      code_q   <= '0;
      float_q  <= 1'b0;
    end else begin
      en_q     <= en_d;
      pin_q    <= pin_d;
      pin_oe_q <= pin_oe_d;
      done_q   <= done_d;
      code_q   <= code_d;
      float_q  <= float_d;
    end
  end

  assign clk_pin_out             = pin_q;
  assign clk_pin_oe_out          = pin_oe_q;
  assign startup_done_out        = done_q;
  assign active_code_out         = code_q;
  assign float_when_disabled_out = float_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_RESET_STATE: assert property (
    !$past(reset_n_in) |-> state_q == OCS_ST_START && start_cnt_q == '0 && !pin_oe_q
  ) else $error("reset did not restart start-up");

  AST_FLOAT_IN_START: assert property (
    (state_q == OCS_ST_START) |=> !pin_oe_q && !pin_q
  ) else $error("pin driven during start-up");

  AST_START_LENGTH: assert property (
    $rose(done_q) |-> start_cnt_q == START_LAST && $past(state_q, 2) == OCS_ST_START
  ) else $error("start-up ended before its full length");

  AST_START_WAITS_CODE: assert property (
    (state_q == OCS_ST_START) && !(code_if.valid && code_if.settled) |=> state_q == OCS_ST_START
  ) else $error("start-up ended with an unsettled code");

  AST_FIRST_LOW_LONG: assert property (
    ($rose(running) && div_run && code_if.exp >= `OCS_SHORT_EXP) ##1 div_run ##1 div_run
    |-> pin_oe_q && !pin_q && !$past(pin_q) ##1 pin_q
  ) else $error("lead-in low is not one master period");

  AST_FIRST_LOW_SHORT: assert property (
    ($rose(running) && div_run && code_if.exp == 3'h1) ##1 div_run ##1 div_run
    |-> !pin_q && !$past(pin_q) ##1 pin_q
  ) else $error("lead-in low is not half an output period");

  AST_DISABLED_LOW: assert property (
    running && !output_enable_in && !code_if.float_bit |=> pin_oe_q && !pin_q
  ) else $error("disabled pin not held low");

  AST_DISABLED_FLOAT: assert property (
    running && !output_enable_in && code_if.float_bit |=> !pin_oe_q
  ) else $error("disabled pin not floating");

  AST_ENABLED_DRIVES: assert property (
    running && output_enable_in |=> pin_oe_q
  ) else $error("enabled pin not driven");

  AST_CODE_MAP: assert property (
    code_if.valid |-> code_if.float_bit == (code_if.code >= 4'h8) &&
      ((code_if.code < 4'h8) ? ({1'b0, code_if.exp} == code_if.code)
                             : ({1'b0, code_if.exp} == 4'hf - code_if.code))
  ) else $error("code to ratio or float mapping wrong");

  AST_ENABLE_SYNC: assert property (
    (running && $rose(output_enable_in) && code_if.exp >= `OCS_SHORT_EXP) ##1
      (running && output_enable_in)[*3]
    |-> !pin_q ##1 pin_q
  ) else $error("first pulse after enable late or early");

  AST_ENABLE_CUT: assert property (
    running && $fell(output_enable_in) |-> !pin_d ##1 !pin_q
  ) else $error("falling enable did not cut the output");

  AST_FLOAT_SETTLED: assert property (
    $changed(float_q) && running |-> $past(code_if.valid) && float_q == $past(code_if.float_bit)
  ) else $error("float bit changed without a settled code");

  AST_NO_EARLY_RUN: assert property (
    (state_q == OCS_ST_START) && (start_cnt_q != START_LAST) |=> !running
  ) else $error("run entered before the start-up count ended");

endmodule : ocs_top

`default_nettype wire

// File: tb/ocs_top_tb_top.sv
`default_nettype none

module ocs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ocs_pkg::*;

  localparam int MC = 2;
  // Start-up kept longer than the 192 clk first-code window
  localparam int SP = 120;

  logic         clk_in      = 1'b0;
  logic         reset_n_in  = 1'b0;
  ocs_code_type code        = 4'h3;
  logic         en          = 1'b1;
  logic         pin;
  logic         oe;
  logic         done;
  logic         flt;
  ocs_code_type act;
  ocs_code_type prev;
  ocs_code_type c;
  ocs_code_type corner [6] = '{4'h0, 4'hf, 4'h7, 4'h8, 4'h4, 4'hb};
  int           errors      = 0;
  int           checks_done = 0;
  int           cycles      = 0;
  int           hi_run      = 0;
  int           n;
  int           h;
  int           l;

  always #5 clk_in = ~clk_in;

  ocs_top #(.MASTER_CLKS(MC), .START_PERIODS(SP)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .divider_select_code_in(code),
    .output_enable_in(en), .clk_pin_out(pin), .clk_pin_oe_out(oe),
    .startup_done_out(done), .active_code_out(act), .float_when_disabled_out(flt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  function automatic int exp_of(input ocs_code_type k);
    return (k > 4'h7) ? 15 - k : k;
  endfunction : exp_of

  function automatic int need_of(input ocs_code_type a, input ocs_code_type b);
    int d;
    d = (a > b) ? a - b : b - a;
    return 16 * (d + 6) * MC;
  endfunction : need_of

  task automatic rng(input int v, input int lo, input int hi);
    chk(v >= lo && v <= hi, 1);
  endtask : rng

  task automatic run_len(input logic lvl, output int len);
    len = 0;
    while (pin === lvl && len < 400) begin
      len++;
      @(negedge clk_in);
    end
  endtask : run_len

  task automatic do_reset(input ocs_code_type k, input logic e);
    @(negedge clk_in);
    reset_n_in = 1'b0;
    code       = k;
    en         = e;
    repeat (6) @(negedge clk_in);
    chk({pin, oe, done, act, flt}, 0);
    reset_n_in = 1'b1;
  endtask : do_reset

  task automatic wait_done(output int len);
    len = 0;
    while (done !== 1'b1 && len < 2000) begin
      chk(oe, 0);
      len++;
      @(negedge clk_in);
    end
  endtask : wait_done

  task automatic set_code(input ocs_code_type k, output int lat);
    ocs_code_type old;
    old  = act;
    code = k;
    lat  = 0;
    while (act !== k && lat < 1200) begin
      @(negedge clk_in);
      lat++;
      chk(act === old || act === k, 1);
    end
  endtask : set_code

  task automatic period_of(input ocs_code_type k);
    // First periods after a commit may still carry the old ratio
    repeat (2) begin
      run_len(1'b1, n);
      run_len(1'b0, n);
    end
    run_len(1'b1, h);
    run_len(1'b0, l);
    chk(h, 1 << exp_of(k));
    chk(l, 1 << exp_of(k));
  endtask : period_of

  task automatic en_test(input ocs_code_type k);
    do_reset(k, 1'b0);
    wait_done(n);
    repeat (4) @(negedge clk_in);
    chk(oe, !k[3]);
    chk(pin, 0);
    en = 1'b1;
    n  = 0;
    while (pin !== 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    rng(n, 1, 5);
    run_len(1'b1, h);
    chk(h, 1 << exp_of(k));
    run_len(1'b0, n);
    repeat (2) @(negedge clk_in);
    en = 1'b0;
    @(negedge clk_in);
    chk(pin, 0);
    chk(oe, !k[3]);
  endtask : en_test

  // Every completed high pulse under a steady enable must be a whole ratio
  always @(negedge clk_in) begin
    if (!reset_n_in || !en || !done) begin
      hi_run = 0;
    end else if (pin) begin
      hi_run++;
    end else if (hi_run != 0) begin
      chk((hi_run & (hi_run - 1)) == 0 && hi_run <= 128, 1);
      hi_run = 0;
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(46));
    foreach (corner[i]) begin
      if (i < 3) begin
        // Ratio 2 start-up exercises the half output period lead-in
        c = (i == 0) ? 4'h3 : ((i == 1) ? 4'hf : 4'he);
        do_reset(c, 1'b1);
        wait_done(n);
        rng(n, 2 * SP, 2 * SP + 4);
        chk(act, c);
        chk(flt, c[3]);
        n = 0;
        while (oe !== 1'b1 && n < 10) begin
          @(negedge clk_in);
          n++;
        end
        run_len(1'b0, n);
        chk(n, (exp_of(c) >= 2) ? 2 : 1 << exp_of(c));
      end
    end
    prev = c;
    for (int i = 0; i < 12; i++) begin
      c = (i < 6) ? corner[i] : 4'($urandom_range(15));
      if (c == prev) begin
        c = c ^ 4'h9;
      end
      set_code(c, n);
      rng(n, need_of(prev, c), need_of(prev, c) + 3);
      chk(act, c);
      chk(flt, c >= 4'h8);
      period_of(c);
      prev = c;
    end
    code = prev ^ 4'h2;
    repeat (100) @(negedge clk_in);
    code = prev;
    repeat (800) begin
      @(negedge clk_in);
      chk(act, prev);
    end
    en_test(4'h4);
    en_test(4'hc);
    do_reset(4'h2, 1'b1);
    repeat (3) begin
      repeat (150) begin
        chk(done, 0);
        chk(oe, 0);
        @(negedge clk_in);
      end
      code = code + 4'h3;
    end
    wait_done(n);
    rng(n, 192, 200);
    complete_run();
  end

endmodule : ocs_top_tb_top

`default_nettype wire
